/* rtl/hlu_pkg.sv */
// Constants for the head load/unload sequencer.
// Assumes one 40 MHz clock and an APB master with 32-bit data.
package hlu_pkg;

  // ***************************
  // Clock and timing
  // ***************************
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned LONG_TMO_NS     = 1667000000;
  localparam int unsigned AMP_DELAY_NS    = 60000000;
  localparam int unsigned SETTLE_NS       = 1300000;
  localparam int unsigned LONG_TMO_CYC    = LONG_TMO_NS / CLK_PERIOD_NS;
  localparam int unsigned AMP_DELAY_CYC   = AMP_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_CYC      = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 27;

  // ***************************
  // Register map
  // ***************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CLEAR_OFS  = 8'h08;
  localparam logic [7:0] FAULT_OFS  = 8'h0c;

  // Field positions
  localparam int unsigned CTRL_RUN_BIT   = 0;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_READY_BIT   = 1;
  localparam int unsigned ST_FIRST_BIT   = 3;
  localparam int unsigned ST_ATTN_BIT    = 7;
  localparam int unsigned CLR_ATTN_BIT   = 0;
  localparam int unsigned CLR_FIRST_BIT  = 1;
  localparam int unsigned CLR_FAULT_BIT  = 8;

  // Reset values
  localparam logic CTRL_RUN_RST = 1'b0;

  typedef enum logic [2:0] {
    HLU_RETRACTED,
    HLU_HOMING,
    HLU_FINE,
    HLU_SETTLING,
    HLU_READY,
    HLU_UNLOADING
  } hlu_state_e;

endpackage

/* rtl/hlu_sequencer.sv */
// Head load/unload sequencer with status and attention flags.
// Assumes synchronous inputs from servo, spindle and tag bus, APB from software.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
module hlu_sequencer #(
  parameter int unsigned LONG_TMO_CYC  = hlu_pkg::LONG_TMO_CYC,
  parameter int unsigned AMP_DELAY_CYC = hlu_pkg::AMP_DELAY_CYC,
  parameter int unsigned SETTLE_CYC    = hlu_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Drive interlocks and spindle
  input  wire logic        pack_present_n,
  input  wire logic        door_locked_n,
  input  wire logic        spindle_at_speed_n,
  input  wire logic        interlock_trip,
  input  wire logic        unsafe_write_trip,
  input  wire logic        carriage_back,
  // Servo indications
  input  wire logic        servo_gain_valid,
  input  wire logic        track_center_found,
  input  wire logic        address_match,
  input  wire logic        seek_inhibit,
  input  wire logic        servo_ref,
  input  wire logic        target_lsb,
  // Tag bus from controller
  input  wire logic        clear_status_cmd,
  input  wire logic [1:0]  ctl_bus_low,
  input  wire logic        position_cmd,
  // Servo and actuator controls
  output logic             retract_request,
  output logic             seek_home,
  output logic             servo_loop_enable,
  output logic             motor_amp_enable,
  output logic             latch_solenoid,
  output logic             fwd_slew,
  output logic             rev_slew,
  output logic             fine_position,
  output logic             servo_settled_n,
  output logic             phase_invert,
  output logic             peak_gate,
  output logic             hold_cyl0,
  // Status to lamp and controller
  output logic             drive_ready_flag,
  output logic             access_ready_n,
  output logic             ops_enable,
  output logic [7:0]       status_bits
);

  // ***************************
  // State and flags
  // ***************************
  hlu_pkg::hlu_state_e state;
  logic                run_sel;
  logic                gain_loss_fault;
  logic                carriage_home_fault;
  logic                interlock_fault;
  logic                unsafe_write_fault;
  logic                timeout_fault;
  logic                first_status;
  logic                attention;
  logic                gain_prev;
  logic                ready_prev;
  logic                load_phase;
  logic                tmo_run;
  logic [hlu_pkg::CNT_W-1:0] tmo_cnt;
  logic [hlu_pkg::CNT_W-1:0] amp_cnt;
  logic [hlu_pkg::CNT_W-1:0] settle_cnt;

  logic any_fault;
  logic retract_cond;
  logic load_start;
  logic gain_rise;
  logic fine_cond;
  logic cyl_lsb;
  logic settle_done;
  logic bus_wr;
  logic clr_attn;
  logic clr_first;
  logic clr_fault;
  logic ready_rise;
  logic ready_fall;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == hlu_pkg::CTRL_OFS) || (a == hlu_pkg::STATUS_OFS) ||
                (a == hlu_pkg::CLEAR_OFS) || (a == hlu_pkg::FAULT_OFS);
  endfunction

  assign any_fault    = gain_loss_fault | carriage_home_fault | interlock_fault |
                        unsafe_write_fault | timeout_fault;
  assign retract_cond = ~run_sel | any_fault | spindle_at_speed_n;
  assign load_start   = retract_request & ~retract_cond & ~pack_present_n &
                        ~door_locked_n & (state == hlu_pkg::HLU_RETRACTED);
  assign gain_rise    = servo_gain_valid & ~gain_prev;
  assign fine_cond    = ~seek_home & ~retract_request & (address_match | seek_inhibit);
  assign cyl_lsb      = load_phase ? 1'b0 : target_lsb;
  assign settle_done  = (settle_cnt == hlu_pkg::CNT_W'(SETTLE_CYC - 1));
  assign bus_wr       = psel & penable & pready & pwrite;
  assign clr_attn     = (clear_status_cmd & ctl_bus_low[0]) |
                        (bus_wr & (paddr == hlu_pkg::CLEAR_OFS) & pwdata[hlu_pkg::CLR_ATTN_BIT]);
  assign clr_first    = (clear_status_cmd & ctl_bus_low[1]) |
                        (bus_wr & (paddr == hlu_pkg::CLEAR_OFS) & pwdata[hlu_pkg::CLR_FIRST_BIT]);
  assign clr_fault    = bus_wr & (paddr == hlu_pkg::CLEAR_OFS) & pwdata[hlu_pkg::CLR_FAULT_BIT];
  assign ready_rise   = drive_ready_flag & ~ready_prev;
  assign ready_fall   = ~drive_ready_flag & ready_prev;

  // ***************************
  // APB slave
  // ***************************
  // Zero wait states: data is prepared in setup so the access phase ends at once
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~is_mapped(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          hlu_pkg::CTRL_OFS:   prdata <= {31'h0000_0000, run_sel};
          hlu_pkg::STATUS_OFS: prdata <= {24'h00_0000, status_bits};
          hlu_pkg::FAULT_OFS:  prdata <= {27'h000_0000, timeout_fault, unsafe_write_fault,
                                          interlock_fault, carriage_home_fault, gain_loss_fault};
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      run_sel <= hlu_pkg::CTRL_RUN_RST;
    end else if (bus_wr && paddr == hlu_pkg::CTRL_OFS) begin
      run_sel <= pwdata[hlu_pkg::CTRL_RUN_BIT];
    end
  end

  // ***************************
  // Faults
  // ***************************
  // Sticky until software clears; a new trip in the clear cycle wins
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      gain_loss_fault     <= 1'b0;
      carriage_home_fault <= 1'b0;
      interlock_fault     <= 1'b0;
      unsafe_write_fault  <= 1'b0;
      timeout_fault       <= 1'b0;
    end else begin
      gain_loss_fault     <= (drive_ready_flag & ~servo_gain_valid) | (gain_loss_fault & ~clr_fault);
      carriage_home_fault <= (drive_ready_flag & carriage_back) | (carriage_home_fault & ~clr_fault);
      interlock_fault     <= interlock_trip | (interlock_fault & ~clr_fault);
      unsafe_write_fault  <= unsafe_write_trip | (unsafe_write_fault & ~clr_fault);
      timeout_fault       <= (tmo_run & tmo_cnt == hlu_pkg::CNT_W'(LONG_TMO_CYC - 1)) |
                             (timeout_fault & ~clr_fault);
    end
  end

  // ***************************
  // Long timeout
  // ***************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tmo_run <= 1'b0;
      tmo_cnt <= '0;
    end else if (load_start || (retract_cond && !retract_request)) begin
      tmo_run <= 1'b1;
      tmo_cnt <= '0;
    end else if (ready_rise || (retract_request && carriage_back) || timeout_fault) begin
      tmo_run <= 1'b0;
      tmo_cnt <= '0;
    end else if (tmo_run) begin
      tmo_cnt <= tmo_cnt + 1'b1;
    end
  end

  // ***************************
  // Load/unload sequence
  // ***************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state             <= hlu_pkg::HLU_RETRACTED;
      retract_request   <= 1'b1;
      seek_home         <= 1'b0;
      servo_loop_enable <= 1'b0;
      drive_ready_flag  <= 1'b0;
      servo_settled_n   <= 1'b1;
      load_phase        <= 1'b0;
      settle_cnt        <= '0;
    end else begin
      retract_request <= retract_cond;
      if (retract_cond) begin
        seek_home        <= 1'b0;
        drive_ready_flag <= 1'b0;
        servo_settled_n  <= 1'b1;
        settle_cnt       <= '0;
        if (state != hlu_pkg::HLU_RETRACTED) begin
          state <= hlu_pkg::HLU_UNLOADING;
        end
        if (carriage_back) begin
          servo_loop_enable <= 1'b0;
          state             <= hlu_pkg::HLU_RETRACTED;
        end
      end else begin
        case (state)
          hlu_pkg::HLU_RETRACTED: begin
            if (load_start) begin
              seek_home         <= 1'b1;
              servo_loop_enable <= 1'b1;
              load_phase        <= 1'b1;
              state             <= hlu_pkg::HLU_HOMING;
            end
          end
          hlu_pkg::HLU_HOMING: begin
            if (gain_rise) begin
              seek_home <= 1'b0;
              state     <= hlu_pkg::HLU_FINE;
            end
          end
          hlu_pkg::HLU_FINE: begin
            if (track_center_found && fine_position) begin
              servo_settled_n <= 1'b0;
              settle_cnt      <= '0;
              state           <= hlu_pkg::HLU_SETTLING;
            end
          end
          hlu_pkg::HLU_SETTLING: begin
            settle_cnt <= settle_cnt + 1'b1;
            if (settle_done) begin
              drive_ready_flag <= 1'b1;
              state            <= hlu_pkg::HLU_READY;
            end
          end
          hlu_pkg::HLU_READY: begin
            if (position_cmd) begin
              load_phase <= 1'b0;
            end
          end
          hlu_pkg::HLU_UNLOADING: begin
            state <= hlu_pkg::HLU_RETRACTED;
          end
          default: state <= hlu_pkg::HLU_RETRACTED;
        endcase
      end
    end
  end

  // ***************************
  // Motor amplifier delay
  // ***************************
  // Relay contacts need time to close before current flows
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      amp_cnt          <= '0;
      motor_amp_enable <= 1'b0;
    end else if (!servo_loop_enable) begin
      amp_cnt          <= '0;
      motor_amp_enable <= 1'b0;
    end else if (amp_cnt == hlu_pkg::CNT_W'(AMP_DELAY_CYC - 1)) begin
      motor_amp_enable <= 1'b1;
    end else begin
      amp_cnt <= amp_cnt + 1'b1;
    end
  end

  // ***************************
  // Servo drive outputs
  // ***************************
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      fwd_slew       <= 1'b0;
      rev_slew       <= 1'b0;
      fine_position  <= 1'b0;
      latch_solenoid <= 1'b0;
      phase_invert   <= 1'b0;
      peak_gate      <= 1'b0;
      hold_cyl0      <= 1'b0;
      gain_prev      <= 1'b0;
    end else begin
      gain_prev      <= servo_gain_valid;
      fwd_slew       <= seek_home & ~servo_gain_valid & ~gain_rise & ~retract_cond;
      rev_slew       <= retract_cond & servo_loop_enable & ~carriage_back;
      fine_position  <= fine_cond;
      latch_solenoid <= servo_loop_enable & ~retract_cond;
      phase_invert   <= cyl_lsb;
      peak_gate      <= servo_ref ^ cyl_lsb;
      hold_cyl0      <= load_phase & ~servo_settled_n & ~position_cmd & ~retract_cond;
    end
  end

  // ***************************
  // Status and attention
  // ***************************
  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ready_prev     <= 1'b0;
      access_ready_n <= 1'b1;
      ops_enable     <= 1'b0;
      first_status   <= 1'b0;
      attention      <= 1'b0;
      status_bits    <= 8'h01;
    end else begin
      ready_prev     <= drive_ready_flag;
      access_ready_n <= ~drive_ready_flag;
      ops_enable     <= drive_ready_flag;
      first_status   <= ready_rise | (first_status & ~clr_first);
      attention      <= ready_rise | ready_fall | (attention & ~clr_attn);
      status_bits    <= 8'h00;
      status_bits[hlu_pkg::ST_BUSY_BIT]  <= ~drive_ready_flag;
      status_bits[hlu_pkg::ST_READY_BIT] <= drive_ready_flag;
      status_bits[hlu_pkg::ST_FIRST_BIT] <= first_status;
      status_bits[hlu_pkg::ST_ATTN_BIT]  <= attention;
    end
  end

  // ***************************
  // Checks
  // ***************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  load_starts_a: assert property (load_start |=> seek_home && servo_loop_enable && tmo_run)
    else $error("load did not start home seek");
  fwd_slew_a: assert property (seek_home && !servo_gain_valid && !retract_cond && $past(seek_home)
                               |=> fwd_slew)
    else $error("forward slew missing");
  amp_delay_a: assert property ($rose(motor_amp_enable) |-> amp_cnt == hlu_pkg::CNT_W'(AMP_DELAY_CYC - 1))
    else $error("amplifier enabled early");
  gain_edge_a: assert property (gain_rise && state == hlu_pkg::HLU_HOMING && !retract_cond
                                |=> !seek_home ##1 !fwd_slew)
    else $error("home seek not ended on gain edge");
  fine_sel_a: assert property (fine_cond |=> fine_position)
    else $error("fine position not selected");
  peak_gate_a: assert property (##1 peak_gate == ($past(servo_ref) ^ $past(cyl_lsb)))
    else $error("peak gate wrong");
  load_lsb_a: assert property (load_phase |=> !phase_invert)
    else $error("odd phase during load");
  settle_wait_a: assert property ($rose(drive_ready_flag) |-> $past(state) == hlu_pkg::HLU_SETTLING
                                  && !servo_settled_n)
    else $error("ready without settling");
  ready_status_a: assert property ($rose(drive_ready_flag) |=> !access_ready_n ##1
                                   status_bits[hlu_pkg::ST_READY_BIT] && attention)
    else $error("ready effects missing");
  first_clear_a: assert property (first_status && clr_first && !ready_rise |=> !first_status)
    else $error("first status not cleared");
  retract_a: assert property (retract_cond |=> retract_request && !drive_ready_flag && !seek_home)
    else $error("retract not raised");
  timeout_a: assert property (timeout_fault |=> retract_request)
    else $error("timeout did not retract");

endmodule

/* bench/hlu_ctrl_model.sv */
// Disc controller model: issues clear-status and positioning tag commands.
// Assumes requests from the bench, one at a time, after reset is released.
`timescale 1ns/100ps
module hlu_ctrl_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Bench requests
  input  wire logic       req,
  input  wire logic [1:0] sel,
  input  wire logic       slow,
  input  wire logic       pos_req,
  // Tag and control bus
  output logic            clear_status_cmd,
  output logic [1:0]      ctl_bus_low,
  output logic            position_cmd,
  output logic            done
);
  // ***************************
  // Tag bus sequencing
  // ***************************
  logic       pend;
  logic [1:0] dly;
  logic [1:0] held;

  // Idle bus toggles so a stale value is never mistaken for a command
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clear_status_cmd <= 1'b0;
      ctl_bus_low      <= 2'h1;
      position_cmd     <= 1'b0;
      done             <= 1'b0;
      pend             <= 1'b0;
      dly              <= 2'h0;
      held             <= 2'h0;
    end else begin
      clear_status_cmd <= 1'b0;
      ctl_bus_low      <= ~ctl_bus_low;
      position_cmd     <= pos_req;
      done             <= 1'b0;
      if (req) begin
        pend <= 1'b1;
        held <= sel;
        dly  <= slow ? 2'h3 : 2'h0;
      end else if (pend && dly != 2'h0) begin
        dly <= dly - 2'h1;
      end else if (pend) begin
        clear_status_cmd <= 1'b1;
        ctl_bus_low      <= held;
        pend             <= 1'b0;
        done             <= 1'b1;
      end
    end
  end
endmodule

/* bench/tb_hlu_sequencer.sv */
// Testbench for the head load/unload sequencer.
// Assumes short delay counts; controller model drives the tag bus.
`timescale 1ns/100ps
module tb_hlu_sequencer;
  // ***************************
  // Signals and helpers
  // ***************************
  localparam int TMO = 200;
  localparam int AMP = 10;
  localparam int SET = 5;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, status_bits;
  logic [31:0] pwdata, prdata, rd;
  logic pack_present_n, door_locked_n, spindle_at_speed_n, interlock_trip, unsafe_write_trip, carriage_back;
  logic servo_gain_valid, track_center_found, address_match, seek_inhibit, servo_ref, target_lsb;
  logic clear_status_cmd, position_cmd, req, slow, pos_req, done;
  logic [1:0] ctl_bus_low, sel;
  logic retract_request, seek_home, servo_loop_enable, motor_amp_enable, latch_solenoid, fwd_slew, rev_slew;
  logic fine_position, servo_settled_n, phase_invert, peak_gate, hold_cyl0, drive_ready_flag, access_ready_n;
  logic ops_enable;
  int fail_count, checks, wn;

  hlu_sequencer #(.LONG_TMO_CYC(TMO), .AMP_DELAY_CYC(AMP), .SETTLE_CYC(SET)) dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .pack_present_n(pack_present_n),
    .door_locked_n(door_locked_n), .spindle_at_speed_n(spindle_at_speed_n), .interlock_trip(interlock_trip),
    .unsafe_write_trip(unsafe_write_trip), .carriage_back(carriage_back), .servo_gain_valid(servo_gain_valid),
    .track_center_found(track_center_found), .address_match(address_match), .seek_inhibit(seek_inhibit),
    .servo_ref(servo_ref), .target_lsb(target_lsb), .clear_status_cmd(clear_status_cmd),
    .ctl_bus_low(ctl_bus_low), .position_cmd(position_cmd), .retract_request(retract_request),
    .seek_home(seek_home), .servo_loop_enable(servo_loop_enable), .motor_amp_enable(motor_amp_enable),
    .latch_solenoid(latch_solenoid), .fwd_slew(fwd_slew), .rev_slew(rev_slew), .fine_position(fine_position),
    .servo_settled_n(servo_settled_n), .phase_invert(phase_invert), .peak_gate(peak_gate),
    .hold_cyl0(hold_cyl0), .drive_ready_flag(drive_ready_flag), .access_ready_n(access_ready_n),
    .ops_enable(ops_enable), .status_bits(status_bits));

  hlu_ctrl_model ctrl (
    .core_clk(core_clk), .rstn(rstn), .req(req), .sel(sel), .slow(slow), .pos_req(pos_req),
    .clear_status_cmd(clear_status_cmd), .ctl_bus_low(ctl_bus_low), .position_cmd(position_cmd), .done(done));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Request held until pready is seen; idle cycle after avoids double drive
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (n >= 20) chk(0, 1, "apb no ready");
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic sig(input int i);
    case (i)
      0: return retract_request;
      1: return seek_home;
      2: return servo_settled_n;
      3: return drive_ready_flag;
      4: return motor_amp_enable;
      5: return servo_loop_enable;
      default: return done;
    endcase
  endfunction

  task automatic wait_for(input int i, input logic v, input int lim);
    wn = 0;
    while (sig(i) !== v && wn < lim) begin @(posedge core_clk); wn++; end
    if (wn >= lim) chk(sig(i), v, "wait timed out");
  endtask

  task automatic clr(input logic [1:0] s, input logic sl, input logic [7:0] exp);
    sel <= s; slow <= sl; req <= 1'b1;
    tick(1);
    req <= 1'b0;
    wait_for(6, 1'b1, 12);
    tick(3);
    chk(status_bits, exp, "status after clear");
  endtask

  task automatic ref_loop(input logic inv);
    for (int k = 0; k < 2; k++) begin
      servo_ref <= k[0];
      tick(3);
      chk(peak_gate, k[0] ^ inv, "peak gate");
    end
  endtask

  task automatic complete_run;
    $display("counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  initial begin
    #(5000 * 25);
    fail_count++;
    complete_run();
  end

  // ***************************
  // Tests
  // ***************************
  initial begin
    rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    pack_present_n = 0; door_locked_n = 0; spindle_at_speed_n = 0; interlock_trip = 0; unsafe_write_trip = 0;
    carriage_back = 0; servo_gain_valid = 0; track_center_found = 0; address_match = 0; seek_inhibit = 0;
    servo_ref = 0; target_lsb = 0; req = 0; sel = 2'h0; slow = 0; pos_req = 0;
    tick(12);
    rstn <= 1'b1;
    tick(1);
    chk(status_bits, 8'h01, "reset status");
    apb(1'b1, hlu_pkg::STATUS_OFS, 32'hff);
    apb(1'b0, hlu_pkg::STATUS_OFS, 32'h0);
    chk(rd, 32'h01, "status read only");
    apb(1'b0, 8'h10, 32'h0);
    chk({rd[30:0], er}, 32'h1, "unmapped");
    tick(3);
    chk(retract_request, 1'b1, "stopped retract");
    $display("test reset done");
    target_lsb <= 1'b1;
    apb(1'b1, hlu_pkg::CTRL_OFS, 32'h1);
    wait_for(0, 1'b0, 10);
    wait_for(5, 1'b1, 20);
    wait_for(4, 1'b1, AMP + 5);
    chk(wn >= AMP - 1 && wn <= AMP + 1, 1, "amp delay");
    chk({seek_home, fwd_slew, latch_solenoid, phase_invert}, 4'he, "homing");
    ref_loop(1'b0);
    $display("test load done");
    servo_gain_valid <= 1'b1;
    tick(3);
    chk({seek_home, fwd_slew, fine_position}, 3'h0, "gain edge");
    seek_inhibit <= 1'b1;
    tick(3);
    chk(fine_position, 1'b1, "fine by inhibit");
    seek_inhibit <= 1'b0;
    address_match <= 1'b1;
    tick(3);
    chk(fine_position, 1'b1, "fine by match");
    track_center_found <= 1'b1;
    wait_for(2, 1'b0, 5);
    wait_for(3, 1'b1, SET + 5);
    chk(wn >= SET - 1 && wn <= SET + 1, 1, "settle delay");
    tick(4);
    chk({access_ready_n, ops_enable, status_bits}, 10'h18a, "ready");
    tick(TMO + 20);
    chk({retract_request, hold_cyl0}, 2'h1, "timeout cancelled");
    $display("test settle done");
    clr(2'h1, 1'b0, 8'h0a);
    clr(2'h2, 1'b1, 8'h02);
    $display("test clear done");
    pos_req <= 1'b1;
    tick(1);
    pos_req <= 1'b0;
    tick(3);
    chk({hold_cyl0, phase_invert}, 2'h1, "odd cylinder");
    ref_loop(1'b1);
    $display("test position done");
    apb(1'b1, hlu_pkg::CTRL_OFS, 32'h0);
    wait_for(0, 1'b1, 5);
    tick(3);
    chk({drive_ready_flag, seek_home, latch_solenoid, rev_slew}, 4'h1, "unload");
    chk({access_ready_n, status_bits}, 9'h181, "unload status");
    carriage_back <= 1'b1;
    tick(3);
    chk(servo_loop_enable, 1'b0, "servo off");
    $display("test unload done");
    carriage_back <= 1'b0;
    servo_gain_valid <= 1'b0;
    track_center_found <= 1'b0;
    address_match <= 1'b0;
    apb(1'b1, hlu_pkg::CTRL_OFS, 32'h1);
    wait_for(1, 1'b1, 20);
    wait_for(0, 1'b1, TMO + 10);
    chk(wn >= TMO - 5 && wn <= TMO + 5, 1, "timeout");
    apb(1'b0, hlu_pkg::FAULT_OFS, 32'h0);
    chk(rd, 32'h10, "timeout fault");
    apb(1'b1, hlu_pkg::CLEAR_OFS, 32'h100);
    wait_for(0, 1'b0, 10);
    interlock_trip <= 1'b1;
    wait_for(0, 1'b1, 5);
    interlock_trip <= 1'b0;
    apb(1'b0, hlu_pkg::FAULT_OFS, 32'h0);
    chk(rd, 32'h04, "interlock fault");
    spindle_at_speed_n <= 1'b1;
    apb(1'b1, hlu_pkg::CLEAR_OFS, 32'h100);
    tick(5);
    chk(retract_request, 1'b1, "no load without speed");
    $display("test faults done");
    complete_run();
  end
endmodule
